/* design/csr_pkg.sv */
// Shared constants for the core system register bank.
// Assumes a 9-bit data-memory address space and 8-bit data.
package csr_pkg;

  // Widths
  localparam int unsigned CSR_ADDR_W   = 9;
  localparam int unsigned CSR_DATA_W   = 8;
  localparam int unsigned CSR_PC_W     = 13;
  localparam int unsigned CSR_IRQ_SRCS = 8;
  localparam int unsigned CSR_EXT_PINS = 4;

  // Register addresses in data memory
  localparam logic [8:0] CSR_A_INDIRECT_PORT_0   = 9'h000;
  localparam logic [8:0] CSR_A_INDIRECT_PORT_1   = 9'h001;
  localparam logic [8:0] CSR_A_PTR0   = 9'h002;
  localparam logic [8:0] CSR_A_PTR1   = 9'h003;
  localparam logic [8:0] CSR_A_STATUS = 9'h004;
  localparam logic [8:0] CSR_A_ACC    = 9'h005;
  localparam logic [8:0] CSR_A_IFLG   = 9'h006;
  localparam logic [8:0] CSR_A_IEN    = 9'h007;
  localparam logic [8:0] CSR_A_IFLG2  = 9'h016;
  localparam logic [8:0] CSR_A_IEN2   = 9'h017;

  // ALU status and interrupt-enable field positions
  localparam int unsigned CSR_ST_PAGE1 = 7;
  localparam int unsigned CSR_ST_PAGE0 = 6;
  localparam int unsigned CSR_ST_PWRDN = 4;
  localparam int unsigned CSR_ST_WDOG  = 3;
  localparam int unsigned CSR_ST_DIGC  = 2;
  localparam int unsigned CSR_ST_CARRY = 1;
  localparam int unsigned CSR_ST_ZERO  = 0;
  localparam int unsigned CSR_IEN_GIE  = 7;

  // Interrupt source slots; slots 0..4 sit in the first flag register,
  // slots 5..7 in the extended one, low bits first
  localparam int unsigned CSR_SRC_EXT0  = 0;
  localparam int unsigned CSR_SRC_EXT1  = 1;
  localparam int unsigned CSR_SRC_CONV  = 2;
  localparam int unsigned CSR_SRC_SER   = 3;
  localparam int unsigned CSR_SRC_TMR   = 4;
  localparam int unsigned CSR_SRC_EXT2  = 5;
  localparam int unsigned CSR_SRC_EXT3  = 6;
  localparam int unsigned CSR_SRC_CAPT  = 7;
  localparam int unsigned CSR_LO_SRCS   = 5;

  // Reset values and interrupt vector
  localparam logic [7:0]  CSR_STATUS_RST = 8'h00;
  localparam logic [7:0]  CSR_REG_RST    = 8'h00;
  localparam logic [7:0]  CSR_IRQ_RST    = 8'h00;
  localparam logic [12:0] CSR_IRQ_VECTOR = 13'h0004;

  // ALU operation classes
  typedef enum logic [1:0] {CSR_ALU_ADD, CSR_ALU_SUB, CSR_ALU_LOGIC}
    csr_alu_kind_t;

endpackage

/* design/csr_alu_flags.sv */
// Arithmetic flag generator for the ALU status register.
// Assumes operands come from the core's own clock domain; pure logic.
`timescale 1ns/1ps
module csr_alu_flags
  import csr_pkg::*;
(
  input  wire logic [7:0]    op_a_in,
  input  wire logic [7:0]    op_b_in,
  input  wire logic [7:0]    logic_res_in,
  input  wire csr_alu_kind_t kind_in,
  output logic      [7:0]    result_out,
  output logic               zero_out,
  output logic               carry_out,
  output logic               digit_carry_out,
  output logic               arith_out
);

  logic       is_sub;
  logic [7:0] b_eff;
  logic [8:0] sum;
  logic [4:0] nib;

  // Subtraction is a + ~b + 1, so carry reads as not-borrow
  assign is_sub    = (kind_in == CSR_ALU_SUB);
  assign b_eff     = is_sub ? ~op_b_in : op_b_in;
  assign sum       = {1'b0, op_a_in} + {1'b0, b_eff} + {8'h00, is_sub};
  assign nib       = {1'b0, op_a_in[3:0]} + {1'b0, b_eff[3:0]}
                     + {4'h0, is_sub};
  assign arith_out = (kind_in != CSR_ALU_LOGIC);

  // Flag results
  assign result_out      = arith_out ? sum[7:0] : logic_res_in;
  assign zero_out        = (result_out == 8'h00);
  assign carry_out       = sum[8];
  assign digit_carry_out = nib[4];

endmodule

/* design/csr_irq_ctrl.sv */
// Interrupt flag and enable bits with the request combiner.
// Assumes events are one-cycle pulses on the same clock as the writes.
`timescale 1ns/1ps
module csr_irq_ctrl
  import csr_pkg::*;
#(
  parameter int unsigned N = CSR_IRQ_SRCS
)(
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [N-1:0] evt_in,
  input  wire logic [N-1:0] flag_wr_in,
  input  wire logic [N-1:0] en_wr_in,
  input  wire logic [N-1:0] wdata_in,
  input  wire logic         gie_wr_in,
  input  wire logic         gie_wdata_in,
  output logic      [N-1:0] flags_out,
  output logic      [N-1:0] en_out,
  output logic              gie_out,
  output logic              irq_req_out
);

  // One flag and one enable per source; a set beats a same-cycle clear
  for (genvar i = 0; i < N; i++)
  begin : g_src
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        flags_out[i] <= CSR_IRQ_RST[0];
      else if (evt_in[i])
        flags_out[i] <= 1'b1;
      else if (flag_wr_in[i])
        flags_out[i] <= wdata_in[i];
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        en_out[i] <= CSR_IRQ_RST[0];
      else if (en_wr_in[i])
        en_out[i] <= wdata_in[i];
    end
  end

  // Global enable
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      gie_out <= CSR_IRQ_RST[CSR_IEN_GIE];
    else if (gie_wr_in)
      gie_out <= gie_wdata_in;
  end

  // Request is combinational so the core sees it with no extra delay
  assign irq_req_out = gie_out && |(flags_out & en_out);

endmodule

/* design/csr_regbank.sv */
// Core system register bank: indirect ports, pointers, ALU status,
// accumulator and interrupt registers, reached at data-memory addresses.
// Assumes a same-clock core and an asynchronous-read data memory.
// Operation
// - Reading an indirect port returns memory at its pointer's address.
// - Writing an indirect port stores the byte at its pointer's address.
// - Indirect ports keep no storage; their address only redirects.
// - Status bit 7 is the page bit for pointer 1.
// - Status bit 6 is the page bit for pointer 0.
// - A flag-updating instruction's write to status leaves zero/carry flags.
// - Power-down and watchdog flags ignore instruction writes.
// - Sleep sets power-down flag; power-on reset clears it.
// - Watchdog time-out sets only its flag; power-on reset clears it.
// - Digit carry is carry out of bit 3, inverted as borrow.
// - Carry is carry out of bit 7, inverted as borrow.
// - Zero flag set when the operation result is zero.
// - Global enable passes enabled sources; clear blocks all.
// - Enable register holds timer, serial, converter, pin1, pin0 enables.
// - Flags set by events stay set until software clears them.
// - Enables bits 1 and 0 gate port 2 pin 1 and pin 0 interrupts.
// - Interrupt enable and flag registers read and write normally.
// - Taking an interrupt loads the fixed vector into the counter.
`timescale 1ns/1ps
module csr_regbank
  import csr_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                rst_n_in,
  input  wire logic                wdt_timeout_in,
  input  wire logic                sleep_exec_in,
  input  wire logic [8:0]          reg_addr_in,
  input  wire logic                reg_rd_in,
  input  wire logic                reg_wr_in,
  input  wire logic [7:0]          reg_wdata_in,
  output logic      [7:0]          reg_rdata_out,
  output logic                     reg_rvalid_out,
  input  wire logic                alu_upd_in,
  input  wire csr_alu_kind_t       alu_kind_in,
  input  wire logic [7:0]          alu_a_in,
  input  wire logic [7:0]          alu_b_in,
  input  wire logic [7:0]          alu_logic_in,
  output logic      [7:0]          alu_result_out,
  input  wire logic                timer_evt_in,
  input  wire logic                serial_evt_in,
  input  wire logic                conv_evt_in,
  input  wire logic                capture_evt_in,
  input  wire logic [3:0]          ext_pin_in,
  input  wire logic                irq_ack_in,
  output logic                     irq_req_out,
  output logic                     pc_load_out,
  output logic      [12:0]         pc_vector_out,
  output logic      [7:0]          accum_out,
  output logic      [8:0]          dmem_addr_out,
  output logic                     dmem_rd_out,
  output logic                     dmem_wr_out,
  output logic      [7:0]          dmem_wdata_out,
  input  wire logic [7:0]          dmem_rdata_in
);

  logic [7:0] ptr0;
  logic [7:0] ptr1;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_lvl;
  logic       ind_rd_pend;
  logic [CSR_IRQ_SRCS-1:0] irq_evt;
  logic [CSR_IRQ_SRCS-1:0] irq_flags;
  logic [CSR_IRQ_SRCS-1:0] irq_en;
  logic [CSR_IRQ_SRCS-1:0] flag_wr;
  logic [CSR_IRQ_SRCS-1:0] en_wr;
  logic [CSR_IRQ_SRCS-1:0] irq_wdata;
  logic       global_irq_enable;
  logic       f_zero;
  logic       f_carry;
  logic       f_digc;
  logic       f_arith;

  // Address decode
  wire hit_indirect_port_0   = (reg_addr_in == CSR_A_INDIRECT_PORT_0);
  wire hit_indirect_port_1   = (reg_addr_in == CSR_A_INDIRECT_PORT_1);
  wire hit_ptr0   = (reg_addr_in == CSR_A_PTR0);
  wire hit_ptr1   = (reg_addr_in == CSR_A_PTR1);
  wire hit_status = (reg_addr_in == CSR_A_STATUS);
  wire hit_acc    = (reg_addr_in == CSR_A_ACC);
  wire hit_iflg   = (reg_addr_in == CSR_A_IFLG);
  wire hit_ien    = (reg_addr_in == CSR_A_IEN);
  wire hit_iflg2  = (reg_addr_in == CSR_A_IFLG2);
  wire hit_ien2   = (reg_addr_in == CSR_A_IEN2);
  wire hit_ind    = hit_indirect_port_0 || hit_indirect_port_1;
  wire hit_direct = hit_ptr0 || hit_ptr1 || hit_status || hit_acc ||
                    hit_iflg || hit_ien || hit_iflg2 || hit_ien2;

  // Indirect target: page bit from status on top of the pointer
  wire [8:0] indirect_port_0_addr = {status[CSR_ST_PAGE0], ptr0};
  wire [8:0] indirect_port_1_addr = {status[CSR_ST_PAGE1], ptr1};
  wire [8:0] ind_addr  = hit_indirect_port_1 ? indirect_port_1_addr : indirect_port_0_addr;
  wire       ind_rd    = reg_rd_in && hit_ind;
  wire       ind_wr    = reg_wr_in && hit_ind;

  // Read selection of the directly stored registers
  wire [7:0] st_view = {status[7:6], 1'b0, status[4:0]};
  wire [7:0] iflg_v  = {3'h0, irq_flags[CSR_LO_SRCS-1:0]};
  wire [7:0] ien_v   = {global_irq_enable, 2'h0, irq_en[CSR_LO_SRCS-1:0]};
  wire [7:0] iflg2_v = {5'h00, irq_flags[CSR_IRQ_SRCS-1:CSR_LO_SRCS]};
  wire [7:0] ien2_v  = {5'h00, irq_en[CSR_IRQ_SRCS-1:CSR_LO_SRCS]};
  wire [7:0] direct_rd =
    hit_ptr0   ? ptr0      :
    hit_ptr1   ? ptr1      :
    hit_status ? st_view   :
    hit_acc    ? accum_out :
    hit_iflg   ? iflg_v    :
    hit_ien    ? ien_v     :
    hit_iflg2  ? iflg2_v   :
    hit_ien2   ? ien2_v    : 8'h00;

  // Pin events: a rise counts once stages two and three agree
  wire [3:0] pin_agree    = ~(pin_s2 ^ pin_s3);
  wire [3:0] next_pin_lvl = (pin_agree & pin_s3) | (~pin_agree & pin_lvl);
  wire [3:0] pin_rise     = next_pin_lvl & ~pin_lvl;   // Glitch-free edge

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      {pin_lvl, pin_s3, pin_s2, pin_s1} <= 16'h0000;
    else
      {pin_lvl, pin_s3, pin_s2, pin_s1} <= {next_pin_lvl, pin_s2, pin_s1,
                                            ext_pin_in};
  end

  // Event routing into source slots
  always_comb
  begin
    irq_evt                = '0;
    irq_evt[CSR_SRC_EXT0]  = pin_rise[0];
    irq_evt[CSR_SRC_EXT1]  = pin_rise[1];
    irq_evt[CSR_SRC_CONV]  = conv_evt_in;
    irq_evt[CSR_SRC_SER]   = serial_evt_in;
    irq_evt[CSR_SRC_TMR]   = timer_evt_in;
    irq_evt[CSR_SRC_EXT2]  = pin_rise[2];
    irq_evt[CSR_SRC_EXT3]  = pin_rise[3];
    irq_evt[CSR_SRC_CAPT]  = capture_evt_in;
  end

  // Write strobes per source; the two registers share one data lane
  wire wr_iflg  = reg_wr_in && hit_iflg;
  wire wr_iflg2 = reg_wr_in && hit_iflg2;
  wire wr_ien   = reg_wr_in && hit_ien;
  wire wr_ien2  = reg_wr_in && hit_ien2;
  assign flag_wr   = {{3{wr_iflg2}}, {5{wr_iflg}}};
  assign en_wr     = {{3{wr_ien2}}, {5{wr_ien}}};
  assign irq_wdata = wr_iflg2 || wr_ien2 ?
                     {reg_wdata_in[2:0], 5'h00} :
                     {3'h0, reg_wdata_in[4:0]};

  csr_irq_ctrl #(
    .N (CSR_IRQ_SRCS)
  ) u_irq (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .evt_in       (irq_evt),
    .flag_wr_in   (flag_wr),
    .en_wr_in     (en_wr),
    .wdata_in     (irq_wdata),
    .gie_wr_in    (wr_ien),
    .gie_wdata_in (reg_wdata_in[CSR_IEN_GIE]),
    .flags_out    (irq_flags),
    .en_out       (irq_en),
    .gie_out      (global_irq_enable),
    .irq_req_out  (irq_req_out)
  );

  csr_alu_flags u_flags (
    .op_a_in         (alu_a_in),
    .op_b_in         (alu_b_in),
    .logic_res_in    (alu_logic_in),
    .kind_in         (alu_kind_in),
    .result_out      (alu_result_out),
    .zero_out        (f_zero),
    .carry_out       (f_carry),
    .digit_carry_out (f_digc),
    .arith_out       (f_arith)
  );

  // Status next value; flag logic beats an instruction write
  wire wr_status = reg_wr_in && hit_status;
  always_comb
  begin
    next_status = status;
    if (wr_status)
      next_status[7:6] = reg_wdata_in[7:6];
    if (sleep_exec_in)
      next_status[CSR_ST_PWRDN] = 1'b1;
    if (wdt_timeout_in)
      next_status[CSR_ST_WDOG] = 1'b1;
    if (alu_upd_in)
    begin
      next_status[CSR_ST_ZERO] = f_zero;
      if (f_arith)
      begin
        next_status[CSR_ST_CARRY] = f_carry;
        next_status[CSR_ST_DIGC]  = f_digc;
      end
    end
    else if (wr_status)
      next_status[2:0] = reg_wdata_in[2:0];
  end

  // Status, pointers and accumulator; power-on reset clears them all
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status    <= CSR_STATUS_RST;
      ptr0      <= CSR_REG_RST;
      ptr1      <= CSR_REG_RST;
      accum_out <= CSR_REG_RST;
    end
    else
    begin
      status <= next_status;
      if (reg_wr_in && hit_ptr0)
        ptr0 <= reg_wdata_in;
      if (reg_wr_in && hit_ptr1)
        ptr1 <= reg_wdata_in;
      if (reg_wr_in && hit_acc)
        accum_out <= reg_wdata_in;
    end
  end

  // Indirect access goes out to memory one cycle after the request;
  // no port value is kept, only the address and data in flight
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dmem_addr_out  <= 9'h000;
      dmem_rd_out    <= 1'b0;
      dmem_wr_out    <= 1'b0;
      dmem_wdata_out <= 8'h00;
    end
    else
    begin
      dmem_rd_out <= ind_rd;
      dmem_wr_out <= ind_wr;
      if (ind_rd || ind_wr)
        dmem_addr_out <= ind_addr;
      if (ind_wr)
        dmem_wdata_out <= reg_wdata_in;
    end
  end

  // Read return: direct reads after one edge, indirect after two
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ind_rd_pend    <= 1'b0;
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      ind_rd_pend    <= ind_rd;
      reg_rvalid_out <= ind_rd_pend || (reg_rd_in && hit_direct);
      if (ind_rd_pend)
        reg_rdata_out <= dmem_rdata_in;
      else if (reg_rd_in && hit_direct)
        reg_rdata_out <= direct_rd;
    end
  end

  // Vector load when the core accepts a pending request
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pc_load_out   <= 1'b0;
      pc_vector_out <= 13'h0000;
    end
    else
    begin
      pc_load_out <= irq_req_out && irq_ack_in;
      if (irq_req_out && irq_ack_in)
        pc_vector_out <= CSR_IRQ_VECTOR;
    end
  end

  // Checks on the bank's own outputs
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  wire [8:0] chk_sum = {1'b0, alu_a_in} + {1'b0, alu_b_in};
  wire [4:0] chk_nib = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]};

  indirect_port_0_read_a: assert property (
    (reg_rd_in && hit_indirect_port_0) |=> dmem_rd_out &&
      dmem_addr_out == {$past(status[CSR_ST_PAGE0]), $past(ptr0)}
      ##1 reg_rvalid_out && reg_rdata_out == $past(dmem_rdata_in))
    else $error("indirect read 0 not redirected");
  indirect_port_1_write_a: assert property (
    (reg_wr_in && hit_indirect_port_1) |=> dmem_wr_out &&
      dmem_wdata_out == $past(reg_wdata_in) &&
      dmem_addr_out == {$past(status[CSR_ST_PAGE1]), $past(ptr1)})
    else $error("indirect write 1 not redirected");
  ind_nostore_a: assert property (
    (ind_wr && !alu_upd_in && !sleep_exec_in && !wdt_timeout_in)
      |=> $stable(ptr0) && $stable(ptr1) && $stable(status)
          && $stable(accum_out))
    else $error("indirect write changed a stored register");
  flag_guard_a: assert property (
    (wr_status && alu_upd_in && alu_kind_in == CSR_ALU_ADD)
      |=> status[CSR_ST_ZERO] == ($past(chk_sum[7:0]) == 8'h00) &&
          status[CSR_ST_CARRY] == $past(chk_sum[8]))
    else $error("status write overrode flag update");
  pd_hold_a: assert property (
    (wr_status && !sleep_exec_in && !wdt_timeout_in)
      |=> $stable(status[CSR_ST_PWRDN:CSR_ST_WDOG]))
    else $error("power-down or watchdog flag written");
  pd_set_a: assert property (
    sleep_exec_in |=> status[CSR_ST_PWRDN] [*2])
    else $error("sleep did not set power-down flag");
  wdog_only_a: assert property (
    (wdt_timeout_in && !reg_wr_in && !alu_upd_in && !sleep_exec_in)
      |=> status[CSR_ST_WDOG] &&
          status[7:4] == $past(status[7:4]) &&
          status[2:0] == $past(status[2:0]))
    else $error("watchdog event touched other status bits");
  digit_carry_a: assert property (
    (alu_upd_in && alu_kind_in == CSR_ALU_ADD)
      |=> status[CSR_ST_DIGC] == $past(chk_nib[4]))
    else $error("digit carry wrong after add");
  sub_borrow_a: assert property (
    (alu_upd_in && alu_kind_in == CSR_ALU_SUB)
      |=> status[CSR_ST_CARRY] == ($past(alu_a_in) >= $past(alu_b_in)))
    else $error("carry not inverse borrow after subtract");
  zero_flag_a: assert property (
    alu_upd_in |=> status[CSR_ST_ZERO] == ($past(alu_result_out) == 8'h00))
    else $error("zero flag wrong");
  gie_block_a: assert property (
    !global_irq_enable |-> !irq_req_out)
    else $error("request raised with global enable clear");
  pin_gate_a: assert property (
    (irq_flags[1:0] != 2'b00 && irq_en[1:0] == 2'b00 &&
      (irq_flags[7:2] & irq_en[7:2]) == 6'h00) |-> !irq_req_out)
    else $error("pin interrupt passed a cleared enable");
  flag_sticky_a: assert property (
    (irq_flags[CSR_SRC_TMR] && !wr_iflg) |=> irq_flags[CSR_SRC_TMR])
    else $error("interrupt flag dropped without a write");
  enable_rw_a: assert property (
    (wr_ien && !reg_rd_in) ##1 !(reg_wr_in || reg_rd_in) ##1
      (reg_rd_in && hit_ien && !reg_wr_in)
      |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h9f))
    else $error("enable register readback wrong");
  irq_req_a: assert property (
    irq_req_out == (ien_v[CSR_IEN_GIE] &&
      (|(iflg_v & ien_v) || |(iflg2_v & ien2_v))))
    else $error("request does not match flags and enables");
  vector_load_a: assert property (
    (irq_req_out && irq_ack_in) |=> pc_load_out &&
      pc_vector_out == 13'h0004)
    else $error("vector not loaded on interrupt accept");

  ind_read_c: cover property (
    (reg_rd_in && hit_indirect_port_1 && status[CSR_ST_PAGE1]) ##2 reg_rvalid_out);
  irq_take_c: cover property (irq_req_out && irq_ack_in ##1 pc_load_out);
  flag_race_c: cover property (wr_iflg && |irq_evt[CSR_LO_SRCS-1:0]);

endmodule

/* test/csr_dmem_model.sv */
// Behavioural data memory that answers the bank's indirect accesses.
// Assumes address and strobes arrive as registers on the same clock.
`timescale 1ns/1ps
module csr_dmem_model
(
  input  wire logic       clk_in,
  input  wire logic [8:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [0:383];
  logic [7:0] last = 8'h00;

  // Idle bus shows the inverse of the last read, so stale data fails
  assign rdata_out = rd_in ? mem[addr_in] : ~last;

  // Writes land at the edge
  always @(posedge clk_in)
  begin
    if (wr_in)
      mem[addr_in] <= wdata_in;
    if (rd_in)
      last <= mem[addr_in];
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the core system register bank.
// Assumes the bank and the memory model share one 200 MHz clock.
`timescale 1ns/1ps
module tb_top
  import csr_pkg::*;
;
  logic          mclk_in = 1'b0;
  logic          rst_n_in, wdt_timeout_in, sleep_exec_in;
  logic [8:0]    reg_addr_in, dmem_addr_out;
  logic          reg_rd_in, reg_wr_in, reg_rvalid_out, alu_upd_in;
  logic [7:0]    reg_wdata_in, reg_rdata_out, alu_a_in, alu_b_in;
  logic [7:0]    alu_logic_in, alu_result_out, accum_out;
  logic [7:0]    dmem_wdata_out, dmem_rdata_in;
  csr_alu_kind_t alu_kind_in;
  logic          timer_evt_in, serial_evt_in, conv_evt_in, capture_evt_in;
  logic [3:0]    ext_pin_in;
  logic          irq_ack_in, irq_req_out, pc_load_out;
  logic          dmem_rd_out, dmem_wr_out;
  logic [12:0]   pc_vector_out;
  int            n_fail = 0;
  int            n_checks = 0;

  csr_regbank dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .wdt_timeout_in(wdt_timeout_in), .sleep_exec_in(sleep_exec_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .alu_upd_in(alu_upd_in), .alu_kind_in(alu_kind_in),
    .alu_a_in(alu_a_in), .alu_b_in(alu_b_in),
    .alu_logic_in(alu_logic_in), .alu_result_out(alu_result_out),
    .timer_evt_in(timer_evt_in), .serial_evt_in(serial_evt_in),
    .conv_evt_in(conv_evt_in), .capture_evt_in(capture_evt_in),
    .ext_pin_in(ext_pin_in), .irq_ack_in(irq_ack_in),
    .irq_req_out(irq_req_out), .pc_load_out(pc_load_out),
    .pc_vector_out(pc_vector_out), .accum_out(accum_out),
    .dmem_addr_out(dmem_addr_out), .dmem_rd_out(dmem_rd_out),
    .dmem_wr_out(dmem_wr_out), .dmem_wdata_out(dmem_wdata_out),
    .dmem_rdata_in(dmem_rdata_in));

  csr_dmem_model mem (.clk_in(mclk_in), .addr_in(dmem_addr_out),
    .rd_in(dmem_rd_out), .wr_in(dmem_wr_out),
    .wdata_in(dmem_wdata_out), .rdata_out(dmem_rdata_in));

  // Free-running 5 ns clock
  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic summarize();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle high pulse on any bench-driven strobe
  task automatic pulse(ref logic s);
    @(negedge mclk_in);
    s = 1'b1;
    @(negedge mclk_in);
    s = 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask

  // With none set, the read must never be answered
  task automatic rd(input logic [8:0] a, input logic [7:0] e,
                    input bit none = 1'b0);
    int i;
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge mclk_in);
    reg_rd_in = 1'b0;
    for (i = 0; i < 4 && reg_rvalid_out !== 1'b1; i++)
      @(negedge mclk_in);
    if (none)
      chk(reg_rvalid_out, 16'h0000);
    else if (reg_rvalid_out !== 1'b1)
    begin
      n_fail++;
      summarize();
    end
    else
      chk(reg_rdata_out, e);
  endtask

  // Flag update, optionally with a same-cycle status write of 0x87
  task automatic alu(input csr_alu_kind_t k, input logic [7:0] a, b,
                     input logic [7:0] r, st, input bit w = 1'b0);
    @(negedge mclk_in);
    alu_kind_in = k;
    alu_a_in = a;
    alu_b_in = b;
    alu_upd_in = 1'b1;
    reg_addr_in = CSR_A_STATUS;
    reg_wdata_in = 8'h87;
    reg_wr_in = w;
    #1 chk(alu_result_out, r);
    @(negedge mclk_in);
    alu_upd_in = 1'b0;
    reg_wr_in = 1'b0;
    rd(CSR_A_STATUS, st);
  endtask

  task automatic t_reset();
    rd(CSR_A_STATUS, 8'h00);
    rd(CSR_A_IFLG, 8'h00);
    rd(CSR_A_IEN, 8'h00);
    rd(CSR_A_IFLG2, 8'h00);
    rd(CSR_A_IEN2, 8'h00);
    wr(9'h008, 8'hff);
    rd(9'h008, 8'h00, 1'b1);
  endtask

  // Same pointer value, different pages per port
  task automatic t_indirect();
    wr(CSR_A_STATUS, 8'h80);
    wr(CSR_A_PTR0, 8'h42);
    wr(CSR_A_PTR1, 8'h42);
    wr(CSR_A_INDIRECT_PORT_0, 8'h3c);
    wr(CSR_A_INDIRECT_PORT_1, 8'h5a);
    // The memory takes the write one edge after the bank issues it
    @(negedge mclk_in);
    chk(mem.mem[9'h042], 8'h3c);
    chk(mem.mem[9'h142], 8'h5a);
    rd(CSR_A_INDIRECT_PORT_0, 8'h3c);
    rd(CSR_A_INDIRECT_PORT_1, 8'h5a);
    rd(CSR_A_STATUS, 8'h80);
    wr(CSR_A_ACC, 8'ha5);
    rd(CSR_A_ACC, 8'ha5);
    chk(accum_out, 16'h00a5);
  endtask

  task automatic t_alu();
    alu(CSR_ALU_ADD, 8'h0f, 8'h01, 8'h10, 8'h84);
    alu(CSR_ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h87);
    alu(CSR_ALU_SUB, 8'h10, 8'h01, 8'h0f, 8'h82);
    alu(CSR_ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h87);
    alu(CSR_ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h87);
    alu_logic_in = 8'h5a;
    alu(CSR_ALU_LOGIC, 8'h00, 8'h00, 8'h5a, 8'h86);
    alu(CSR_ALU_ADD, 8'h01, 8'h01, 8'h02, 8'h80, 1'b1);
  endtask

  task automatic t_power();
    pulse(sleep_exec_in);
    rd(CSR_A_STATUS, 8'h90);
    pulse(wdt_timeout_in);
    rd(CSR_A_STATUS, 8'h98);
    wr(CSR_A_STATUS, 8'h00);
    rd(CSR_A_STATUS, 8'h18);
    // Power-on reset in mid-run clears both power flags
    rst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rst_n_in = 1'b1;
    rd(CSR_A_STATUS, 8'h00);
  endtask

  task automatic t_irq();
    int i;
    wr(CSR_A_IEN, 8'h90);
    rd(CSR_A_IEN, 8'h90);
    pulse(timer_evt_in);
    chk(irq_req_out, 16'h0001);
    rd(CSR_A_IFLG, 8'h10);
    pulse(irq_ack_in);
    for (i = 0; i < 4 && pc_load_out !== 1'b1; i++)
      @(negedge mclk_in);
    chk(pc_load_out, 16'h0001);
    chk(pc_vector_out, CSR_IRQ_VECTOR);
    pulse(conv_evt_in);
    rd(CSR_A_IFLG, 8'h14);
    wr(CSR_A_IEN, 8'h10);
    chk(irq_req_out, 16'h0000);
    wr(CSR_A_IFLG, 8'h00);
    rd(CSR_A_IFLG, 8'h00);
    wr(CSR_A_IEN, 8'h81);
    ext_pin_in = 4'h1;
    repeat (5) @(negedge mclk_in);
    chk(irq_req_out, 16'h0001);
    rd(CSR_A_IFLG, 8'h01);
    wr(CSR_A_IEN, 8'h80);
    chk(irq_req_out, 16'h0000);
    pulse(serial_evt_in);
    rd(CSR_A_IFLG, 8'h09);
    pulse(capture_evt_in);
    rd(CSR_A_IFLG2, 8'h04);
    wr(CSR_A_IEN2, 8'h04);
    rd(CSR_A_IEN2, 8'h04);
    chk(irq_req_out, 16'h0001);
    ext_pin_in = 4'hd;
    repeat (5) @(negedge mclk_in);
    rd(CSR_A_IFLG2, 8'h07);
  endtask

  // Main sequence: reset held four cycles, then each scenario
  initial
  begin
    {rst_n_in, wdt_timeout_in, sleep_exec_in, reg_rd_in} = 4'h0;
    {reg_wr_in, alu_upd_in, timer_evt_in, serial_evt_in} = 4'h0;
    {conv_evt_in, capture_evt_in, irq_ack_in} = 3'h0;
    {reg_addr_in, reg_wdata_in, alu_a_in, alu_b_in} = 33'h0;
    alu_logic_in = 8'h00;
    alu_kind_in = CSR_ALU_ADD;
    ext_pin_in = 4'h0;
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_indirect();
    t_alu();
    t_power();
    t_irq();
    summarize();
  end
endmodule
